// ### verif/cpu_instr_decode_or_to_rlc_bench.sv
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, e, m) begin check_count++; if ((a) !== (e)) begin miscompares++; \
  $display("MISMATCH t=%0t %s", $time, m); end end
module cpu_instr_decode_or_to_rlc_bench;
  typedef struct {int cyc; logic il; logic [7:0] fl; logic [7:0] mk; logic [11:0] sp; logic [11:0] a; logic [7:0] v;}
    cpudec_note_s;
  logic        clock = 1'b0;
  logic        nrst = 1'b0;
  logic [7:0]  wrk_base;
  wire  [15:0] pm_addr, pc;
  wire  [11:0] rf_addr, sp;
  wire  [7:0]  pm_data, rf_rdata, rf_wdata, flags;
  wire         rf_we, instr_done, illegal;
  cpudec_note_s notes[$];
  cpudec_note_s cur;
  logic [7:0]  sh [0:4095];
  logic [7:0]  fl, r, res;
  logic [11:0] spv, w;
  int          pa, cyc, miscompares, check_count;
  logic        pend = 1'b0;
  always #10 clock = ~clock;
  cpudec_core cpudec_core_i (.clock(clock), .nrst(nrst), .pm_addr(pm_addr), .pm_data(pm_data), .rf_addr(rf_addr),
    .rf_rdata(rf_rdata), .rf_wdata(rf_wdata), .rf_we(rf_we), .wrk_base(wrk_base), .pc(pc), .sp(sp), .flags(flags),
    .instr_done(instr_done), .illegal(illegal));
  cpudec_mem_model cpudec_mem_model_i (.clock(clock), .pm_addr(pm_addr), .pm_data(pm_data), .rf_addr(rf_addr),
    .rf_rdata(rf_rdata), .rf_wdata(rf_wdata), .rf_we(rf_we));
  task automatic ins(input int n, input logic [31:0] code, input int ex, input logic [11:0] a, input logic [7:0] m);
    cpudec_note_s t;
    for (int i = 0; i < n; i++) begin
      cpudec_mem_model_i.pm[pa] = code[31-8*i -: 8];
      pa++;
    end
    t = '{n + ex, 1'b0, fl, m, spv, a, sh[a]};
    notes.push_back(t);
  endtask
  task automatic zs(input logic [7:0] v);
    fl[6] = v == 8'h00;
    fl[5] = v[7];
    fl[4] = 1'b0;
  endtask
  task automatic summarize;
    $display("comparisons %0d mismatches %0d", check_count, miscompares);
    if (miscompares == 0 && check_count > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  ////////////////////////////////////////////////////////////////////////
  // result checker: counts cycles per instruction, then state after it
  always @(negedge clock) begin
    if (!nrst) cyc = 1;
    else cyc++;
    if (pend) begin
      pend = 1'b0;
      `CHK(flags & cur.mk, cur.fl & cur.mk, "flags")
      `CHK(sp, cur.sp, "stack pointer")
      `CHK(cpudec_mem_model_i.rf[cur.a], cur.v, "stored result")
    end
    if (nrst && instr_done === 1'b1 && notes.size() > 0) begin
      cur = notes.pop_front();
      `CHK(cyc, cur.cyc, "cycle count")
      `CHK(illegal, cur.il, "illegal flag")
      pend = 1'b1;
    end
    if (instr_done === 1'b1) cyc = 0;
  end
  ////////////////////////////////////////////////////////////////////////
  initial begin
    void'($urandom(1750));
    wrk_base = $urandom;
    fl = 8'h00;
    spv = 12'h000;
    pa = 0;
    for (int i = 0; i < 4096; i++) sh[i] = $urandom;
    sh[12'h012] = 8'h00;
    sh[12'h015] = 8'h16;
    sh[12'h017] = 8'h18;
    sh[{4'h0, wrk_base[7:4], 4'hA}] = 8'h20;
    sh[12'h021] = 8'h22;
    sh[12'h024] = 8'h25;
    for (int i = 0; i < 4096; i++) cpudec_mem_model_i.rf[i] = sh[i];
    for (int i = 0; i < 256; i++) cpudec_mem_model_i.pm[i] = 8'h00;
    // or with an escaped working-register source, then an or giving zero
    w = {4'h0, wrk_base[7:4], 4'h5};
    sh[12'h011] |= sh[w]; zs(sh[12'h011]); ins(3, 32'h44E51100, 3, 12'h011, 8'hFF);
    zs(8'h00); ins(3, 32'h46120000, 3, 12'h012, 8'hFF);
    sh[12'h231] |= sh[12'h130]; zs(sh[12'h231]); ins(4, 32'h48130231, 3, 12'h231, 8'hFF);
    sh[12'h232] |= 8'h80; zs(sh[12'h232]); ins(4, 32'h49800232, 3, 12'h232, 8'hFF);
    // plain, extended and prefixed-immediate pushes, then pops back to plain, extended, indirect places
    spv--; sh[spv] = sh[12'h011]; ins(2, 32'h70110000, 2, spv, 8'hFF);
    spv--; sh[spv] = sh[12'h130]; ins(3, 32'hC8130000, 2, spv, 8'hFF);
    spv--; sh[spv] = 8'h5A; ins(3, 32'h1F705A00, 2, spv, 8'hFF);
    sh[12'h040] = sh[spv]; spv++; ins(2, 32'h50400000, 2, 12'h040, 8'hFF);
    sh[12'h141] = sh[spv]; spv++; ins(3, 32'hD8141000, 2, 12'h141, 8'hFF);
    sh[12'h018] = sh[spv]; spv++; ins(2, 32'h51170000, 3, 12'h018, 8'hFF);
    // rotates; overflow marks a change of sign
    r = sh[12'h013]; res = {r[6:0], r[7]}; fl[7] = r[7]; sh[12'h013] = res; zs(res); fl[4] = res[7] ^ r[7];
    ins(2, 32'h90130000, 2, 12'h013, 8'hFF);
    r = sh[12'h014]; res = {r[6:0], fl[7]}; fl[7] = r[7]; sh[12'h014] = res; zs(res); fl[4] = res[7] ^ r[7];
    ins(2, 32'h10140000, 2, 12'h014, 8'hFF);
    r = sh[12'h016]; res = {r[6:0], r[7]}; fl[7] = r[7]; sh[12'h016] = res; zs(res); fl[4] = res[7] ^ r[7];
    ins(2, 32'h91150000, 3, 12'h016, 8'hFF);
    // working-register pair and indirect or forms, then an indirect push
    w = {4'h0, wrk_base[7:4], 4'h8};
    sh[w] |= sh[w + 12'h001]; zs(sh[w]); ins(2, 32'h42890000, 3, w, 8'hFF);
    sh[w] |= sh[12'h020]; zs(sh[w]); ins(2, 32'h438A0000, 4, w, 8'hFF);
    sh[12'h023] |= sh[12'h022]; zs(sh[12'h023]); ins(3, 32'h45212300, 4, 12'h023, 8'hFF);
    sh[12'h025] |= 8'h0F; zs(sh[12'h025]); ins(3, 32'h47240F00, 4, 12'h025, 8'hFF);
    spv--; sh[spv] = sh[12'h022]; ins(2, 32'h71210000, 3, spv, 8'hFF);
    // return through a pushed address onto an unknown opcode
    spv--; sh[spv] = 8'h40; ins(3, 32'h1F704000, 2, spv, 8'hFF);
    spv--; sh[spv] = 8'h00; ins(3, 32'h1F700000, 2, spv, 8'hFF);
    spv = spv + 12'h002; ins(1, 32'hAF000000, 4, 12'h000, 8'hFF);
    pa = 8'h40; ins(1, 32'h00000000, 1, 12'h000, 8'hFF);
    notes[notes.size()-1].il = 1'b1;
    repeat (6) @(negedge clock);
    nrst <= 1'b1;
    for (int i = 0; i < 2000 && notes.size() > 0; i++) @(negedge clock);
    repeat (3) @(negedge clock);
    $display("test instruction_mix done, %0d notes left", notes.size());
    `CHK(notes.size(), 0, "instructions missing")
    summarize();
  end
  initial begin
    #100000;
    miscompares++;
    $display("MISMATCH t=%0t watchdog expired", $time);
    summarize();
  end
endmodule
`default_nettype wire

// ### verif/cpudec_core_assertions.sv
`timescale 1ns/1ps
`default_nettype none
module cpudec_core_assertions (
  input wire logic        clock,
  input wire logic        nrst,
  input wire logic [15:0] pm_addr,
  input wire logic [7:0]  pm_data,
  input wire logic [11:0] rf_addr,
  input wire logic [7:0]  rf_wdata,
  input wire logic        rf_we,
  input wire logic [15:0] pc,
  input wire logic [11:0] sp,
  input wire logic [7:0]  flags,
  input wire logic        instr_done,
  input wire logic        illegal
);
  logic       fetch_q;
  logic [7:0] opc_q;
  logic [1:0] ph_q;
  logic [7:0] b1_q;
  logic [7:0] b2_q;
  // the opcode is the byte taken in the cycle after each done pulse
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      fetch_q <= 1'b1;
      opc_q   <= 8'h00;
      ph_q    <= 2'h0;
      b1_q    <= 8'h00;
      b2_q    <= 8'h00;
    end else begin
      fetch_q <= instr_done;
      if (fetch_q) opc_q <= pm_data;
      ph_q <= fetch_q ? 2'h1 : ((ph_q == 2'h0) ? 2'h0 : ph_q + 2'h1);
      if (ph_q == 2'h1) b1_q <= pm_data;
      if (ph_q == 2'h2) b2_q <= pm_data;
    end
  end
  wire is_pop  = opc_q == 8'h50 || opc_q == 8'h51 || opc_q == 8'hD8;
  wire is_push = opc_q == 8'h70 || opc_q == 8'h71 || opc_q == 8'hC8 || opc_q == 8'h1F;
  wire is_or   = opc_q >= 8'h42 && opc_q <= 8'h49;
  wire is_rl   = opc_q == 8'h90 || opc_q == 8'h91;
  wire is_rlc  = opc_q == 8'h10 || opc_q == 8'h11;
  default clocking cb @(posedge clock); endclocking
  default disable iff (!nrst);
  a_pc_advance: assert property (fetch_q |=> pc == $past(pc) + 16'h0001 && pm_addr == pc)
    else $error("pc did not advance past the opcode");
  a_operand_order: assert property (rf_we && (opc_q == 8'h44 || opc_q == 8'h45) && b2_q[7:4] != 4'hE
    |-> rf_addr == {4'h0, b2_q}) else $error("or result not written to third byte");
  a_illegal_done: assert property (illegal |-> instr_done && !is_or && !is_pop && !is_rl && !is_rlc
    && opc_q != 8'hAF) else $error("illegal pulse on a supported opcode");
  a_pop_sp_up: assert property (rf_we && is_pop |=> sp == $past(sp) + 12'h001 && flags == $past(flags))
    else $error("pop stack pointer or flags wrong");
  a_push_sp_down: assert property (rf_we && is_push |=> sp == $past(sp) - 12'h001 && flags == $past(flags))
    else $error("push stack pointer or flags wrong");
  a_push_top_write: assert property (rf_we && is_push |-> rf_addr == sp - 12'h001)
    else $error("push wrote away from new top");
  a_ret_sp_two: assert property (instr_done && opc_q == 8'hAF |-> sp == $past(sp) + 12'h002)
    else $error("return stack pointer wrong");
  a_or_flags_kept: assert property (instr_done && is_or |=> !flags[4] && flags[7] == $past(flags[7])
    && flags[3:2] == $past(flags[3:2])) else $error("or flag effects wrong");
  a_result_zs: assert property (rf_we && (is_or || is_rl || is_rlc) |=> flags[6] == ($past(rf_wdata) == 8'h00)
    && flags[5] == $past(rf_wdata[7])) else $error("zero or sign flag wrong");
  a_rl_carry: assert property (rf_we && is_rl |=> flags[7] == $past(rf_wdata[0]))
    else $error("rotate carry differs from bit 0");
  a_rlc_bit0: assert property (rf_we && is_rlc |-> rf_wdata[0] == flags[7])
    else $error("old carry not in bit 0");
endmodule
bind cpudec_core cpudec_core_assertions cpudec_core_assertions_i (.clock, .nrst, .pm_addr, .pm_data, .rf_addr,
  .rf_wdata, .rf_we, .pc, .sp, .flags, .instr_done, .illegal);
`default_nettype wire

// ### verif/cpudec_mem_model.sv
`timescale 1ns/1ps
`default_nettype none
module cpudec_mem_model (
  input  wire logic        clock,
  input  wire logic [15:0] pm_addr,
  output logic      [7:0]  pm_data,
  input  wire logic [11:0] rf_addr,
  output logic      [7:0]  rf_rdata,
  input  wire logic [7:0]  rf_wdata,
  input  wire logic        rf_we
);
  // program store wraps every 256 bytes; keep programs short
  logic [7:0] pm [0:255];
  logic [7:0] rf [0:4095];
  assign pm_data  = pm[pm_addr[7:0]];
  assign rf_rdata = rf[rf_addr];
  always @(posedge clock) begin
    if (rf_we) rf[rf_addr] <= rf_wdata;
  end
endmodule
`default_nettype wire

// ### verilog/cpudec_alu.sv
`timescale 1ns/1ps
`default_nettype none
module cpudec_alu (
  input  wire logic [2:0] op,
  input  wire logic [7:0] dst,
  input  wire logic [7:0] src,
  input  wire logic       cin,
  output logic      [7:0] res,
  output logic            cout,
  output logic            zero,
  output logic            sign,
  output logic            ovf
);
  wire is_or  = (op == cpudec_pkg::CPUDEC_OR);
  wire is_rlc = (op == cpudec_pkg::CPUDEC_RLC);

  assign res  = is_or  ? (dst | src)
              : is_rlc ? {dst[6:0], cin}
              :          {dst[6:0], dst[7]};
  assign cout = dst[7];
  assign zero = (res == 8'h00);
  assign sign = res[7];
  // rotate overflow: sign changed by the shift
  assign ovf  = is_or ? 1'b0 : (res[7] ^ dst[7]);
endmodule
`default_nettype wire

// ### verilog/cpudec_core.sv
`timescale 1ns/1ps
`default_nettype none
// Behaviour
// - two-register object code is opcode, then source byte, then destination byte
// - register operand addresses 0-255; upper nibble E selects a working register
// - OR opcodes 42-47 store dst OR src; Z,S follow, V cleared, rest kept
// - extended OR 48/49 same operation and flags; 4 fetch, 3 execute cycles
// - pop 50/51 loads dst from @SP then SP+1; flags untouched
// - extended pop D8 same as pop; 3 fetch, 2 execute cycles
// - push 70,71,1F70,C8 decrements SP then writes source; flags untouched
// - return AF loads PC from two stack bytes, SP+2; 1 fetch, 4 execute
// - rotate through carry 10/11: bit7 to carry, old carry to bit0
// - rotate left 90/91: bit7 to carry and bit0; C,Z,S,V follow
// - flags are computed, unchanged, undefined or cleared per instruction
module cpudec_core (
  input  wire logic        clock,
  input  wire logic        nrst,
  output logic      [15:0] pm_addr,
  input  wire logic [7:0]  pm_data,
  output logic      [11:0] rf_addr,
  input  wire logic [7:0]  rf_rdata,
  output logic      [7:0]  rf_wdata,
  output logic             rf_we,
  input  wire logic [7:0]  wrk_base,
  output logic      [15:0] pc,
  output logic      [11:0] sp,
  output logic      [7:0]  flags,
  output logic             instr_done,
  output logic             illegal
);
  ////////////////////////////////////////////////////////////////////////
  function automatic logic [11:0] reg8(input logic [7:0] b, input logic [7:0] base);
    reg8 = (b[7:4] == cpudec_pkg::ESC_NIBBLE) ? {4'h0, base[7:4], b[3:0]} : {4'h0, b};
  endfunction

  function automatic logic [1:0] fetch_len(input logic [7:0] o);
    case (o)
      cpudec_pkg::OPC_ORX_ER, cpudec_pkg::OPC_ORX_IM:                 fetch_len = cpudec_pkg::FETCH_4;
      cpudec_pkg::OPC_OR_R_R, cpudec_pkg::OPC_OR_R_IR, cpudec_pkg::OPC_OR_R_IM,
      cpudec_pkg::OPC_OR_IR_IM, cpudec_pkg::OPC_POP_EXTENDED, cpudec_pkg::OPC_PUSH_EXTENDED,
      cpudec_pkg::OPC_PREFIX:                                          fetch_len = cpudec_pkg::FETCH_3;
      cpudec_pkg::OPC_OR_RR, cpudec_pkg::OPC_OR_RIR, cpudec_pkg::OPC_POP_R,
      cpudec_pkg::OPC_POP_IR, cpudec_pkg::OPC_PUSH_R, cpudec_pkg::OPC_PUSH_IR,
      cpudec_pkg::OPC_RL_R, cpudec_pkg::OPC_RL_IR, cpudec_pkg::OPC_RLC_R,
      cpudec_pkg::OPC_RLC_IR:                                          fetch_len = cpudec_pkg::FETCH_2;
      default:                                                         fetch_len = cpudec_pkg::FETCH_1;
    endcase
  endfunction

  ////////////////////////////////////////////////////////////////////////
  cpudec_pkg::cpudec_state_e state_q, state_d;
  logic [7:0]  opc_q, b1_q, b2_q, b3_q;
  logic [1:0]  idx_q, len_q;
  logic [2:0]  ecnt_q;
  logic [7:0]  sval_q, dval_q;
  logic [11:0] sptr_q, dptr_q;
  logic [15:0] pc_q;
  logic [11:0] sp_q;
  logic [7:0]  flags_q;

  // decode from the opcode on the bus while fetching so a one-byte
  // instruction can pick its first phase on the same edge
  wire [7:0] eop    = (state_q == cpudec_pkg::ST_FETCH) ? pm_data : opc_q;
  wire       pfx    = (eop == cpudec_pkg::OPC_PREFIX) && (b1_q == cpudec_pkg::OPC_PUSH_R);
  wire       or_rr  = (eop == cpudec_pkg::OPC_OR_RR) || (eop == cpudec_pkg::OPC_OR_RIR);
  wire       or_r   = (eop >= cpudec_pkg::OPC_OR_R_R) && (eop <= cpudec_pkg::OPC_OR_IR_IM);
  wire       or_extended    = (eop == cpudec_pkg::OPC_ORX_ER) || (eop == cpudec_pkg::OPC_ORX_IM);
  wire       popr   = (eop == cpudec_pkg::OPC_POP_R) || (eop == cpudec_pkg::OPC_POP_IR);
  wire       pop_extended   = (eop == cpudec_pkg::OPC_POP_EXTENDED);
  wire       pushr  = (eop == cpudec_pkg::OPC_PUSH_R) || (eop == cpudec_pkg::OPC_PUSH_IR);
  wire       push_extended  = (eop == cpudec_pkg::OPC_PUSH_EXTENDED);
  wire       rl     = (eop == cpudec_pkg::OPC_RL_R) || (eop == cpudec_pkg::OPC_RL_IR);
  wire       rlc    = (eop == cpudec_pkg::OPC_RLC_R) || (eop == cpudec_pkg::OPC_RLC_IR);
  wire       ret    = (eop == cpudec_pkg::OPC_RET);
  wire       ind    = eop[0];   // odd opcode in each group but 48/49 is the indirect form

  wire [2:0] op = (or_rr || or_r || or_extended) ? cpudec_pkg::CPUDEC_OR
                : (popr || pop_extended)         ? cpudec_pkg::CPUDEC_POP
                : (pushr || push_extended || pfx) ? cpudec_pkg::CPUDEC_PUSH
                : ret ? cpudec_pkg::CPUDEC_RET
                : rl  ? cpudec_pkg::CPUDEC_RL
                : rlc ? cpudec_pkg::CPUDEC_RLC : cpudec_pkg::CPUDEC_NOP;

  // immediate forms: 46,47,49 and prefixed push
  wire src_imm = (eop == cpudec_pkg::OPC_OR_R_IM) || (eop == cpudec_pkg::OPC_OR_IR_IM)
              || (eop == cpudec_pkg::OPC_ORX_IM) || pfx;
  wire src_ind = ind && (or_rr || or_r || pushr) && !src_imm;
  wire dst_ind = (ind && (popr || rl || rlc)) || (eop == cpudec_pkg::OPC_OR_IR_IM);
  wire stk_rd  = (op == cpudec_pkg::CPUDEC_POP) || ret;
  wire n_srd   = !src_imm && (op != cpudec_pkg::CPUDEC_NOP) && !rl && !rlc;
  wire n_drd   = (op == cpudec_pkg::CPUDEC_OR) || rl || rlc || ret;

  // operand fields: source byte precedes destination byte in object code
  wire [11:0] src_addr = or_rr ? {4'h0, wrk_base[7:4], b1_q[3:0]}
                       : or_extended   ? {b1_q, b2_q[7:4]}
                       : push_extended ? {b1_q, b2_q[7:4]}
                       :         reg8(b1_q, wrk_base);
  wire [11:0] dst_addr = or_rr ? {4'h0, wrk_base[7:4], b1_q[7:4]}
                       : (or_extended)   ? {b2_q[3:0], b3_q}
                       : pop_extended  ? {b1_q, b2_q[7:4]}
                       : (or_r && !src_imm) ? reg8(b2_q, wrk_base)
                       :         reg8(b1_q, wrk_base);
  wire [7:0]  imm      = (pfx || (or_r && src_imm)) ? b2_q : b1_q;

  wire [2:0] exec_len = (op == cpudec_pkg::CPUDEC_NOP) ? cpudec_pkg::EXEC_1
                      : ret  ? cpudec_pkg::EXEC_4
                      : or_extended  ? cpudec_pkg::EXEC_3
                      : (pop_extended || push_extended || pfx) ? cpudec_pkg::EXEC_2
                      : (popr || pushr || rl || rlc) ? (ind ? cpudec_pkg::EXEC_3 : cpudec_pkg::EXEC_2)
                      : (ind ? cpudec_pkg::EXEC_4 : cpudec_pkg::EXEC_3);

  ////////////////////////////////////////////////////////////////////////
  // phase chain, skipping what the instruction does not need
  cpudec_pkg::cpudec_state_e from_drd, from_dptr, from_srd, first_ph;
  assign from_drd  = cpudec_pkg::ST_WR;
  assign from_dptr = n_drd ? cpudec_pkg::ST_DRD : from_drd;
  assign from_srd  = dst_ind ? cpudec_pkg::ST_DPTR : from_dptr;
  assign first_ph  = src_ind ? cpudec_pkg::ST_SPTR : (n_srd ? cpudec_pkg::ST_SRD : from_srd);

  wire last_exec = ({1'b0, ecnt_q} + 4'h1) >= {1'b0, exec_len};
  wire last_byte = (idx_q == len_q);

  wire [7:0] alu_res;
  wire       alu_c, alu_z, alu_s, alu_v;
  cpudec_alu cpudec_alu_i (
    .op   (op),
    .dst  (dval_q),
    .src  (sval_q),
    .cin  (flags_q[cpudec_pkg::FLG_C]),
    .res  (alu_res),
    .cout (alu_c),
    .zero (alu_z),
    .sign (alu_s),
    .ovf  (alu_v)
  );

  always_comb begin
    state_d = state_q;
    case (state_q)
      cpudec_pkg::ST_FETCH: state_d = (fetch_len(pm_data) == cpudec_pkg::FETCH_1) ? first_ph
                                                                                    : cpudec_pkg::ST_OPND;
      cpudec_pkg::ST_OPND:  state_d = last_byte ? first_ph : cpudec_pkg::ST_OPND;
      cpudec_pkg::ST_SPTR:  state_d = n_srd ? cpudec_pkg::ST_SRD : from_srd;
      cpudec_pkg::ST_SRD:   state_d = from_srd;
      cpudec_pkg::ST_DPTR:  state_d = from_dptr;
      cpudec_pkg::ST_DRD:   state_d = from_drd;
      cpudec_pkg::ST_WR,
      cpudec_pkg::ST_PAD:   state_d = last_exec ? cpudec_pkg::ST_FETCH : cpudec_pkg::ST_PAD;
      default:              state_d = cpudec_pkg::ST_FETCH;
    endcase
  end

  ////////////////////////////////////////////////////////////////////////
  wire is_sptr = (state_q == cpudec_pkg::ST_SPTR);
  wire is_srd  = (state_q == cpudec_pkg::ST_SRD);
  wire is_dptr = (state_q == cpudec_pkg::ST_DPTR);
  wire is_drd  = (state_q == cpudec_pkg::ST_DRD);
  wire is_wr   = (state_q == cpudec_pkg::ST_WR);
  wire is_push = (op == cpudec_pkg::CPUDEC_PUSH);
  wire is_exec = !(state_q == cpudec_pkg::ST_FETCH) && !(state_q == cpudec_pkg::ST_OPND);
  wire fetching = (state_q == cpudec_pkg::ST_FETCH) || (state_q == cpudec_pkg::ST_OPND);
  wire [11:0] dst_eff = dst_ind ? dptr_q : dst_addr;
  wire [11:0] sp_dec  = sp_q - 12'h001;

  assign rf_addr = is_sptr ? src_addr
                 : is_srd  ? (stk_rd ? sp_q : (src_ind ? sptr_q : src_addr))
                 : is_dptr ? dst_addr
                 : is_drd  ? (ret ? (sp_q + 12'h001) : dst_eff)
                 : is_push ? sp_dec : dst_eff;
  assign rf_we    = is_wr && !ret && (op != cpudec_pkg::CPUDEC_NOP);
  // push immediate writes in its first execute cycle, before sval_q holds the byte
  assign rf_wdata = pfx ? imm
                  : ((op == cpudec_pkg::CPUDEC_POP) || is_push) ? sval_q : alu_res;
  assign pm_addr  = pc_q;
  assign pc       = pc_q;
  assign sp       = sp_q;
  assign flags    = flags_q;
  assign instr_done = is_exec && (state_d == cpudec_pkg::ST_FETCH);
  assign illegal  = instr_done && (op == cpudec_pkg::CPUDEC_NOP);

  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      state_q <= cpudec_pkg::ST_FETCH;
      {opc_q, b1_q, b2_q, b3_q} <= 32'h00000000;
      {idx_q, len_q} <= 4'h0;
      ecnt_q <= 3'h0;
      {sval_q, dval_q} <= 16'h0000;
      {sptr_q, dptr_q} <= 24'h000000;
      pc_q <= cpudec_pkg::PC_RESET;
      sp_q <= cpudec_pkg::SP_RESET;
      flags_q <= cpudec_pkg::FLAGS_RESET;
    end else begin
      state_q <= state_d;
      ecnt_q  <= is_exec ? (ecnt_q + 3'h1) : 3'h0;
      if (fetching) begin
        pc_q <= pc_q + 16'h0001;
      end
      if (state_q == cpudec_pkg::ST_FETCH) begin
        opc_q <= pm_data;
        len_q <= fetch_len(pm_data);
        idx_q <= 2'h1;
      end
      if (state_q == cpudec_pkg::ST_OPND) begin
        idx_q <= idx_q + 2'h1;
        case (idx_q)
          2'h1:    b1_q <= pm_data;
          2'h2:    b2_q <= pm_data;
          default: b3_q <= pm_data;
        endcase
      end
      if (is_exec && ecnt_q == 3'h0 && src_imm) begin
        sval_q <= imm;
      end
      if (is_sptr) begin
        sptr_q <= reg8(rf_rdata, wrk_base);
      end
      if (is_srd) begin
        sval_q <= rf_rdata;
      end
      if (is_dptr) begin
        dptr_q <= reg8(rf_rdata, wrk_base);
      end
      if (is_drd) begin
        dval_q <= rf_rdata;
      end
      if (is_wr) begin
        if (op == cpudec_pkg::CPUDEC_POP) begin
          sp_q <= sp_q + 12'h001;
        end
        if (is_push) begin
          sp_q <= sp_dec;
        end
        if (ret) begin
          pc_q <= {sval_q, dval_q};
          sp_q <= sp_q + 12'h002;
        end
        if (op == cpudec_pkg::CPUDEC_OR) begin
          flags_q[cpudec_pkg::FLG_Z] <= alu_z;
          flags_q[cpudec_pkg::FLG_S] <= alu_s;
          flags_q[cpudec_pkg::FLG_V] <= 1'b0;
        end
        if (rl || rlc) begin
          flags_q[cpudec_pkg::FLG_C] <= alu_c;
          flags_q[cpudec_pkg::FLG_Z] <= alu_z;
          flags_q[cpudec_pkg::FLG_S] <= alu_s;
          flags_q[cpudec_pkg::FLG_V] <= alu_v;
        end
      end
    end
  end
endmodule
`default_nettype wire

// ### verilog/cpudec_pkg.sv
`default_nettype none
package cpudec_pkg;
  // opcodes
  localparam logic [7:0] OPC_OR_RR    = 8'h42;
  localparam logic [7:0] OPC_OR_RIR   = 8'h43;
  localparam logic [7:0] OPC_OR_R_R   = 8'h44;
  localparam logic [7:0] OPC_OR_R_IR  = 8'h45;
  localparam logic [7:0] OPC_OR_R_IM  = 8'h46;
  localparam logic [7:0] OPC_OR_IR_IM = 8'h47;
  localparam logic [7:0] OPC_ORX_ER   = 8'h48;
  localparam logic [7:0] OPC_ORX_IM   = 8'h49;
  localparam logic [7:0] OPC_POP_R    = 8'h50;
  localparam logic [7:0] OPC_POP_IR   = 8'h51;
  localparam logic [7:0] OPC_POP_EXTENDED     = 8'hD8;
  localparam logic [7:0] OPC_PUSH_R   = 8'h70;
  localparam logic [7:0] OPC_PUSH_IR  = 8'h71;
  localparam logic [7:0] OPC_PREFIX   = 8'h1F;
  localparam logic [7:0] OPC_PUSH_EXTENDED    = 8'hC8;
  localparam logic [7:0] OPC_RET      = 8'hAF;
  localparam logic [7:0] OPC_RL_R     = 8'h90;
  localparam logic [7:0] OPC_RL_IR    = 8'h91;
  localparam logic [7:0] OPC_RLC_R    = 8'h10;
  localparam logic [7:0] OPC_RLC_IR   = 8'h11;
  // escaped working register marker
  localparam logic [3:0] ESC_NIBBLE   = 4'hE;
  // flag bit positions
  localparam int FLG_C = 7;
  localparam int FLG_Z = 6;
  localparam int FLG_S = 5;
  localparam int FLG_V = 4;
  localparam int FLG_D = 3;
  localparam int FLG_H = 2;
  // reset values
  localparam logic [15:0] PC_RESET    = 16'h0000;
  localparam logic [11:0] SP_RESET    = 12'h000;
  localparam logic [7:0]  FLAGS_RESET = 8'h00;
  // fetch byte counts
  localparam logic [1:0] FETCH_1 = 2'h0;
  localparam logic [1:0] FETCH_2 = 2'h1;
  localparam logic [1:0] FETCH_3 = 2'h2;
  localparam logic [1:0] FETCH_4 = 2'h3;
  // execution cycle counts
  localparam logic [2:0] EXEC_1 = 3'h1;
  localparam logic [2:0] EXEC_2 = 3'h2;
  localparam logic [2:0] EXEC_3 = 3'h3;
  localparam logic [2:0] EXEC_4 = 3'h4;

  typedef enum logic [2:0] {
    CPUDEC_NOP  = 3'h0,
    CPUDEC_OR   = 3'h1,
    CPUDEC_POP  = 3'h2,
    CPUDEC_PUSH = 3'h3,
    CPUDEC_RET  = 3'h4,
    CPUDEC_RL   = 3'h5,
    CPUDEC_RLC  = 3'h6
  } cpudec_op_e;

  typedef enum logic [7:0] {
    ST_FETCH = 8'h01,
    ST_OPND  = 8'h02,
    ST_SPTR  = 8'h04,
    ST_SRD   = 8'h08,
    ST_DPTR  = 8'h10,
    ST_DRD   = 8'h20,
    ST_WR    = 8'h40,
    ST_PAD   = 8'h80
  } cpudec_state_e;
endpackage
`default_nettype wire
